/* File: logic/lsp_top.sv */
// serial load port of a multiplexed led display driver
`timescale 1ns/1ps
`default_nettype none
`include "lsp_defines.svh"

module lsp_top
  import lsp_pkg::*;
#(
  parameter int unsigned SLOT_CYCLES = `LSP_SLOT_CYCLES
) (
  input  wire logic                   core_clk,     // 200 mhz core clock
  input  wire logic                   rstn,         // async reset, low
  input  wire logic                   sclk_pin,     // serial clock pin
  input  wire logic                   sdin_pin,     // serial data in pin
  input  wire logic                   enable_n_pin, // port enable, low
  output logic                        sdout_ff,     // serial data out
  output logic [`LSP_CFG_W-1:0]       cfg_ff,       // configuration
  output logic [`LSP_DISP_W-1:0]      disp_ff,      // display register
  output logic [4:0]                  bank_ff,      // cathode bank select
  output logic                        blank_ff      // display blanked
);

  // --------------------------------------------------------------------
  // reset release
  // --------------------------------------------------------------------
  logic rst_a_ff;
  logic rst_n_ff;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_a_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_a_ff <= 1'b1;
      rst_n_ff <= rst_a_ff;
    end
  end

  // --------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------
  logic sclk_a_ff;
  logic sclk_s_ff;
  logic sclk_d_ff;
  logic sdin_a_ff;
  logic sdin_s_ff;
  logic en_a_ff;
  logic en_s_ff;
  logic en_d_ff;

  // serial clock is only sampled, never used as a clock
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sclk_a_ff <= 1'b0;
      sclk_s_ff <= 1'b0;
      sclk_d_ff <= 1'b0;
      sdin_a_ff <= 1'b0;
      sdin_s_ff <= 1'b0;
      en_a_ff   <= 1'b1;
      en_s_ff   <= 1'b1;
      en_d_ff   <= 1'b1;
    end else begin
      sclk_a_ff <= sclk_pin;
      sclk_s_ff <= sclk_a_ff;
      sclk_d_ff <= sclk_s_ff;
      sdin_a_ff <= sdin_pin;
      sdin_s_ff <= sdin_a_ff;
      en_a_ff   <= enable_n_pin;
      en_s_ff   <= en_a_ff;
      en_d_ff   <= en_s_ff;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic en_rise;

  assign sclk_rise = sclk_s_ff & ~sclk_d_ff;
  assign sclk_fall = ~sclk_s_ff & sclk_d_ff;
  assign en_rise   = en_s_ff & ~en_d_ff;

  // --------------------------------------------------------------------
  // port state
  // --------------------------------------------------------------------
  lsp_port_t state_ff;
  lsp_port_t nxt_state;
  logic      act;

  assign act = (state_ff == LSP_SHIFT);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      LSP_IDLE: begin
        // enable low with clock low: port back in step
        if (!en_s_ff && !sclk_s_ff) begin
          nxt_state = LSP_SHIFT;
        end
      end
      LSP_SHIFT: begin
        if (en_s_ff) begin
          nxt_state = LSP_IDLE;
        end
      end
      default: begin
        nxt_state = LSP_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= LSP_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // --------------------------------------------------------------------
  // 24 stage shift register plus half stage on the output
  // --------------------------------------------------------------------
  logic [`LSP_DISP_W-1:0] shift_ff;

  // contents held while the serial clock stands still
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      shift_ff <= `LSP_DISP_RST;
    end else if (act && sclk_rise) begin
      shift_ff <= {shift_ff[`LSP_DISP_W-2:0], sdin_s_ff};
    end
  end

  // half stage feeds the next device of a chain
  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sdout_ff <= 1'b0;
    end else if (!act) begin
      sdout_ff <= 1'b0;
    end else if (sclk_fall) begin
      sdout_ff <= shift_ff[`LSP_DISP_W-1];
    end
  end

  // --------------------------------------------------------------------
  // stream length modulo 24
  // --------------------------------------------------------------------
  logic [`LSP_PHASE_W-1:0] phase_ff;
  logic                    any_ff;

  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      phase_ff <= `LSP_PHASE_DISP;
      any_ff   <= 1'b0;
    end else if (!act) begin
      phase_ff <= `LSP_PHASE_DISP;
      any_ff   <= 1'b0;
    end else if (sclk_rise) begin
      any_ff <= 1'b1;
      if (phase_ff == `LSP_PHASE_LAST) begin
        phase_ff <= `LSP_PHASE_DISP;
      end else begin
        phase_ff <= phase_ff + 5'h01;
      end
    end
  end

  // --------------------------------------------------------------------
  // register load on enable rise
  // --------------------------------------------------------------------
  lsp_target_t tgt;
  logic        load_ff;
  logic        soft_reset_control_bit;

  // target comes only from the length, no address in the stream
  assign tgt = lsp_decode(phase_ff, any_ff);
  assign soft_reset_control_bit = cfg_ff[`LSP_SOFT_RST_BIT];

  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      cfg_ff <= `LSP_CFG_RST;
    end else if (act && en_rise && tgt == LSP_TGT_CFG) begin
      cfg_ff <= shift_ff[`LSP_CFG_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      disp_ff <= `LSP_DISP_RST;
    end else if (act && en_rise) begin
      if (tgt == LSP_TGT_DISP) begin
        disp_ff <= shift_ff;
      end else if (tgt == LSP_TGT_CFG &&
                   !shift_ff[`LSP_SOFT_RST_BIT]) begin
        disp_ff <= `LSP_DISP_RST;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      load_ff <= 1'b0;
    end else begin
      load_ff <= act && en_rise && tgt != LSP_TGT_NONE;
    end
  end

  // --------------------------------------------------------------------
  // bank scanner
  // --------------------------------------------------------------------
  lsp_scan #(
    .SLOT_CYCLES (SLOT_CYCLES)
  ) u_scan (
    .clk      (core_clk),
    .rst_n    (rst_n_ff),
    .load     (load_ff),
    .run      (soft_reset_control_bit),
    .bank_ff  (bank_ff),
    .blank_ff (blank_ff)
  );

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n_ff);

  sequence s_bit_in;
    act && sclk_rise;
  endsequence

  sequence s_load(lsp_target_t t);
    act && en_rise && tgt == t;
  endsequence

  msb_first_a: assert property (
    s_bit_in |=> shift_ff[0] == $past(sdin_s_ff) &&
                 shift_ff[23:1] == $past(shift_ff[22:0]))
    else $error("serial bit not shifted in at lsb");

  cfg_load_a: assert property (
    s_load(LSP_TGT_CFG) |=> cfg_ff == $past(shift_ff[7:0]))
    else $error("configuration not loaded from stream");

  disp_load_a: assert property (
    s_load(LSP_TGT_DISP) |=> disp_ff == $past(shift_ff) ##1 load_ff == 1'b0)
    else $error("display not loaded from stream");

  disp_hold_a: assert property (
    !(act && en_rise) |=> $stable(disp_ff) && $stable(cfg_ff))
    else $error("registers changed without enable rise");

  sdout_fall_a: assert property (
    act && sclk_fall && !en_s_ff |=> sdout_ff == $past(shift_ff[23]))
    else $error("serial out not updated on clock fall");

  idle_low_a: assert property (
    !act |=> sdout_ff == 1'b0 && phase_ff == 5'h00)
    else $error("idle port not held initialised");

  static_hold_a: assert property (
    !sclk_rise |=> $stable(shift_ff))
    else $error("shift register changed without clock rise");

  soft_reset_a: assert property (
    s_load(LSP_TGT_CFG) ##0 !shift_ff[0] |=> disp_ff == 24'h000000 ##1
    blank_ff)
    else $error("soft reset did not clear and blank");

  sequence s_bad_end;
    act && en_rise && tgt == LSP_TGT_NONE;
  endsequence

  short_frame_a: assert property (
    s_bad_end |=> !load_ff && $stable(disp_ff) && $stable(cfg_ff))
    else $error("short frame loaded a register");

  load_pulse_a: assert property (
    act && en_rise && tgt != LSP_TGT_NONE |=> load_ff)
    else $error("register load did not start blanking");

  idle_no_shift_a: assert property (
    !act |=> $stable(shift_ff) && !any_ff)
    else $error("idle port shifted or kept a count");

endmodule // lsp_top
`default_nettype wire

/* File: logic/lsp_defines.svh */
// constants of the serial load port of the led display driver
`ifndef LSP_DEFINES_SVH
`define LSP_DEFINES_SVH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define LSP_CLK_HZ         200000000
`define LSP_CLK_NS         5
`define LSP_REFRESH_HZ     1000
`define LSP_BANKS          5
`define LSP_SLOT_CYCLES    (`LSP_CLK_HZ / (`LSP_REFRESH_HZ * `LSP_BANKS))
`define LSP_BLANK_NS       1000
`define LSP_BLANK_CYCLES   (`LSP_BLANK_NS / `LSP_CLK_NS)

// ----------------------------------------------------------------------
// register layout and reset values
// ----------------------------------------------------------------------
`define LSP_CFG_W          8
`define LSP_DISP_W         24
`define LSP_PHASE_W        5
`define LSP_PHASE_CFG      5'h08
`define LSP_PHASE_DISP     5'h00
`define LSP_PHASE_LAST     5'h17
`define LSP_SOFT_RST_BIT   0
`define LSP_CFG_RST        8'h00
`define LSP_DISP_RST       24'h000000
`define LSP_CHAIN_MAX      6

`endif

/* File: logic/lsp_pkg.sv */
// types and decode function of the serial load port
`default_nettype none
package lsp_pkg;

  typedef enum logic [0:0] {
    LSP_IDLE,
    LSP_SHIFT
  } lsp_port_t;

  typedef enum logic [1:0] {
    LSP_TGT_NONE,
    LSP_TGT_CFG,
    LSP_TGT_DISP
  } lsp_target_t;

  // stream length modulo 24 picks the target register
  function automatic lsp_target_t lsp_decode(input logic [4:0] phase,
                                             input logic       any);
    lsp_target_t t;
    t = LSP_TGT_NONE;
    if (any && phase == 5'h08) begin
      t = LSP_TGT_CFG;
    end else if (any && phase == 5'h00) begin
      t = LSP_TGT_DISP;
    end
    return t;
  endfunction

endpackage
`default_nettype wire

/* File: logic/lsp_scan.sv */
// cathode bank scanner with blanking after each register load
`timescale 1ns/1ps
`default_nettype none
`include "lsp_defines.svh"

module lsp_scan #(
  parameter int unsigned SLOT_CYCLES = `LSP_SLOT_CYCLES
) (
  input  wire logic       clk,       // core clock
  input  wire logic       rst_n,     // synchronised reset, active low
  input  wire logic       load,      // one-cycle register load pulse
  input  wire logic       run,       // scanning allowed
  output logic [4:0]      bank_ff,   // one-hot cathode bank select
  output logic            blank_ff   // display blanked
);

  localparam logic [15:0] SLOT_LAST  = 16'(SLOT_CYCLES - 1);
  localparam logic [15:0] BLANK_LAST = 16'(`LSP_BLANK_CYCLES - 1);

  logic [15:0] slot_ff;
  logic [15:0] blank_cnt_ff;
  logic        blanking_ff;

  // --------------------------------------------------------------------
  // slot timer and bank rotation
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_ff <= 16'h0000;
      bank_ff <= 5'h01;
    end else if (!run) begin
      slot_ff <= 16'h0000;
      bank_ff <= 5'h01;
    end else if (slot_ff == SLOT_LAST) begin
      slot_ff <= 16'h0000;
      bank_ff <= {bank_ff[3:0], bank_ff[4]};
    end else begin
      slot_ff <= slot_ff + 16'h0001;
    end
  end

  // --------------------------------------------------------------------
  // blanking interval
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blanking_ff  <= 1'b0;
      blank_cnt_ff <= 16'h0000;
    end else if (load) begin
      blanking_ff  <= 1'b1;
      blank_cnt_ff <= 16'h0000;
    end else if (blanking_ff) begin
      if (blank_cnt_ff == BLANK_LAST) begin
        blanking_ff <= 1'b0;
      end
      blank_cnt_ff <= blank_cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blank_ff <= 1'b1;
    end else begin
      blank_ff <= load | blanking_ff | !run;
    end
  end

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  blank_on_load_a: assert property (
    @(posedge clk) disable iff (!rst_n) load |=> ##1 blank_ff)
    else $error("load did not blank the display");

  bank_onehot_a: assert property (
    @(posedge clk) disable iff (!rst_n) $onehot(bank_ff))
    else $error("cathode bank select not one-hot");

  bank_slot_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (run && slot_ff != SLOT_LAST) ##1 run |-> $stable(bank_ff))
    else $error("bank changed before its slot ended");

endmodule // lsp_scan
`default_nettype wire

/* File: tb/lsp_host.sv */
// host serial port model driving the load port pins
`timescale 1ns/1ps
`default_nettype none

module lsp_host (
  input  wire logic core_clk,     // core clock, aligns frame start
  input  wire logic sdout_ret,    // serial data coming back
  output logic      sclk_pin,     // serial clock to device
  output logic      sdin_pin,     // serial data to device
  output logic      enable_n_pin  // port enable, active low
);
  // half period of the link clock, no relation to the core clock
  localparam int HALF_NS = 24;
  logic [143:0] rx_ff;            // bits seen on the return line

  // ----------------------------------------------------------------
  // power-up: clock parked low, port disabled
  // ----------------------------------------------------------------
  initial begin
    sclk_pin     = 1'b0;
    sdin_pin     = 1'b0;
    enable_n_pin = 1'b1;
    rx_ff        = '0;
  end

  // ----------------------------------------------------------------
  // one frame, msb first; clock stops for a while after bit gap_at
  // ----------------------------------------------------------------
  task automatic send(input logic [143:0] bits, input int n,
                      input int gap_at);
    @(negedge core_clk);
    #(2*HALF_NS);
    enable_n_pin = 1'b0;
    #(2*HALF_NS);
    for (int i = n - 1; i >= 0; i--) begin
      sdin_pin = bits[i];
      #HALF_NS;
      sclk_pin = 1'b1;
      rx_ff = {rx_ff[142:0], sdout_ret};
      #HALF_NS;
      sclk_pin = 1'b0;
      if (n - 1 - i == gap_at) #2000;
    end
    #HALF_NS;
    enable_n_pin = 1'b1;
    sdin_pin = ~sdin_pin;
  endtask

endmodule // lsp_host
`default_nettype wire

/* File: tb/lsp_top_bench.sv */
// self-checking bench of the serial load port, two devices chained
`timescale 1ns/1ps
`default_nettype none

module lsp_top_bench;
  localparam int SLOT = 20;
  logic        core_clk = 1'b0;
  logic        rstn     = 1'b0;
  logic        sclk_pin, sdin_pin, enable_n_pin;
  logic        sdout_ff, sdout_b, blank_ff;
  logic [7:0]  cfg_ff, cfg_b;
  logic [23:0] disp_ff, disp_b, disp_hold;
  logic [4:0]  bank_ff;
  logic        watch = 1'b0;
  int          mismatches = 0;
  int          checks = 0;

  always #2.5 core_clk = ~core_clk;

  lsp_top #(.SLOT_CYCLES(SLOT)) lsp_top_inst (.core_clk, .rstn,
    .sclk_pin, .sdin_pin, .enable_n_pin, .sdout_ff, .cfg_ff, .disp_ff,
    .bank_ff, .blank_ff);
  lsp_top #(.SLOT_CYCLES(SLOT)) lsp_top_inst2 (.core_clk, .rstn,
    .sclk_pin, .sdin_pin(sdout_ff), .enable_n_pin, .sdout_ff(sdout_b),
    .cfg_ff(cfg_b), .disp_ff(disp_b), .bank_ff(), .blank_ff());
  lsp_host lsp_host_inst (.core_clk, .sdout_ret(sdout_ff), .sclk_pin,
    .sdin_pin, .enable_n_pin);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [23:0] e,
                     input logic [23:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic end_sim;
    if (mismatches == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // display must hold while a frame is shifting
  always @(negedge core_clk) begin
    if (watch) chk("disp_hold", disp_hold, disp_ff);
  end

  // blank must rise after a load and last about the blanking interval
  task automatic t_blank;
    int n;
    n = 8;
    while (blank_ff === 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    checks++;
    if (n < 200 || n > 212) begin
      mismatches++;
      $display("mismatch blank_len expected 200..212 seen %0d", n);
    end
    if (n >= 400) end_sim();
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk("cfg", 24'h000000, 24'(cfg_ff));
    chk("disp", 24'h000000, disp_ff);
    chk("bank", 24'h000001, 24'(bank_ff));
    chk("blank", 24'h000001, 24'(blank_ff));
    chk("sdout", 24'h000000, 24'(sdout_ff));
  endtask

  task automatic t_cfg;
    lsp_host_inst.send(144'hA5, 8, -1);
    tick(8);
    chk("cfg", 24'h0000A5, 24'(cfg_ff));
    chk("disp", 24'h000000, disp_ff);
    chk("sdout", 24'h000000, 24'(sdout_ff));
    t_blank();
  endtask

  task automatic t_disp;
    disp_hold = disp_ff;
    watch = 1'b1;
    lsp_host_inst.send(144'h3C5A96, 24, 11);
    watch = 1'b0;
    tick(8);
    chk("disp", 24'h3C5A96, disp_ff);
    chk("cfg", 24'h0000A5, 24'(cfg_ff));
    t_blank();
  endtask

  task automatic t_bad;
    lsp_host_inst.send(144'h0, 0, -1);
    lsp_host_inst.send(144'hFFF, 12, -1);
    tick(8);
    chk("blank", 24'h000000, 24'(blank_ff));
    chk("cfg", 24'h0000A5, 24'(cfg_ff));
    chk("disp", 24'h3C5A96, disp_ff);
  endtask

  task automatic t_scan;
    logic [4:0] prev;
    int n;
    for (int k = 0; k < 6; k++) begin
      prev = bank_ff;
      n = 0;
      while (bank_ff === prev && n < 100) begin
        tick(1);
        n++;
      end
      if (n >= 100) begin
        mismatches++;
        end_sim();
      end
      chk("bank", 24'({prev[3:0], prev[4]}), 24'(bank_ff));
      if (k > 0) chk("slot", 24'(SLOT), 24'(n));
    end
  endtask

  task automatic t_soft;
    lsp_host_inst.send(144'hA4, 8, -1);
    tick(250);
    chk("cfg", 24'h0000A4, 24'(cfg_ff));
    chk("disp", 24'h000000, disp_ff);
    chk("blank", 24'h000001, 24'(blank_ff));
    chk("bank", 24'h000001, 24'(bank_ff));
    lsp_host_inst.send(144'h01, 8, -1);
    tick(8);
    chk("cfg", 24'h000001, 24'(cfg_ff));
    t_blank();
  endtask

  task automatic t_chain;
    lsp_host_inst.send(144'h5B9966C3, 32, -1);
    tick(8);
    chk("cfg", 24'h0000C3, 24'(cfg_ff));
    chk("cfg_b", 24'h00005B, 24'(cfg_b));
    chk("ret", 24'h00005B, 24'(lsp_host_inst.rx_ff[7:0]));
    lsp_host_inst.send(144'h123456ABCDEF, 48, -1);
    tick(8);
    chk("disp", 24'hABCDEF, disp_ff);
    chk("disp_b", 24'h123456, disp_b);
    chk("sdout", 24'h000000, 24'(sdout_ff));
    chk("sdout_b", 24'h000000, 24'(sdout_b));
  endtask

  // ----------------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    tick(5);
    rstn = 1'b1;
    tick(6);
    t_reset();
    t_cfg();
    t_disp();
    t_bad();
    t_scan();
    t_soft();
    t_chain();
    end_sim();
  end

  initial begin
    #400000;
    mismatches++;
    end_sim();
  end

endmodule // lsp_top_bench
`default_nettype wire
